// ---- tb/nvss_sp_assertions.sv ----
// Port-level checks of the status and write-protection block
module nvss_sp_assertions (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // SPI and protect pins
    input wire logic spi_sck,
    input wire logic spi_cs_n,
    input wire logic spi_si,
    input wire logic spi_so,
    input wire logic spi_so_oe,
    input wire logic wp_n,
    // Nonvolatile engine
    input wire logic nv_busy,
    input wire logic nv_recall_done,
    input wire logic [7:0] nv_status_in,
    input wire logic [7:0] nv_status_out,
    // Commands, array gate, status view
    input wire logic wel_cmd_ok,
    input wire logic [7:0] cmd_opcode,
    input wire logic cmd_valid,
    input wire logic serial_write_ok,
    input wire logic [15:0] array_addr,
    input wire logic array_addr_protected,
    input wire logic [7:0] status_byte
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////////
    // Closing chip select of a status write or latch clear
    sequence frame_end_s;
        $rose(spi_cs_n) && (cmd_opcode == 8'h01 || cmd_opcode == 8'h04);
    endsequence
    // Sync and register lag bound the wait
    sequence wel_gone_s;
        ##[1:8] !wel_cmd_ok;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    unused_zero_a: assert property ((status_byte & 8'h30) == 8'h00)
        else $error("unused status bits set");
    busy_show_a: assert property (nv_busy [*5] |-> status_byte[0])
        else $error("busy not shown");
    lock_hold_a: assert property ($fell(status_byte[6]) |-> $past(nv_recall_done, 2))
        else $error("serial lock cleared");
    wel_frame_a: assert property ($rose(wel_cmd_ok) |-> !spi_cs_n)
        else $error("latch set outside a frame");
    cmd_pulse_a: assert property (cmd_valid |=> !cmd_valid)
        else $error("command pulse too long");
    wel_needed_a: assert property (cmd_valid && cmd_opcode inside {8'h01, 8'h02, 8'hC2}
        |-> $past(wel_cmd_ok))
        else $error("write accepted without latch");
    wel_clear_a: assert property (frame_end_s |-> wel_gone_s)
        else $error("latch not cleared");
    so_idle_a: assert property (spi_cs_n [*6] |-> !spi_so_oe)
        else $error("output driven while deselected");
    prot_all_a: assert property ((status_byte[3:2] == 2'b11) [*3] |-> array_addr_protected)
        else $error("full protect missing");
    prot_half_a: assert property ((status_byte[3:2] == 2'b10 && $stable(array_addr)) [*3]
        |-> array_addr_protected == array_addr[15])
        else $error("half protect wrong");
endmodule // nvss_sp_assertions

bind nvss_status_protect nvss_sp_assertions u_chk (.*);

// ---- tb/nvss_spi_host.sv ----
// SPI host model that frames instructions towards the block
module nvss_spi_host (
    // Clock
    input wire logic sys_clk,
    // SPI pins
    output logic spi_sck,
    output logic spi_cs_n,
    output logic spi_si,
    input wire logic spi_so
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spi_sck = 1'b0;
        spi_cs_n = 1'b1;
        spi_si = 1'b0;
    end
    // Sends nbits of tx from the top; rx keeps the last eight bits seen on spi_so
    task automatic frame(input logic [23:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        @(negedge sys_clk);
        spi_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_si = tx[23 - i];
            repeat (8) @(negedge sys_clk);
            spi_sck = 1'b1;
            rx = {rx[6:0], spi_so};
            repeat (8) @(negedge sys_clk);
            spi_sck = 1'b0;
        end
        repeat (8) @(negedge sys_clk);
        spi_cs_n = 1'b1;
        // Released line must not look like the last bit
        spi_si = ~spi_si;
        repeat (6) @(negedge sys_clk);
    endtask
endmodule // nvss_spi_host

// ---- tb/nvss_status_protect_tb_top.sv ----
// Self-checking bench of the status and write-protection block
module nvss_status_protect_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rst, spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe, wp_n, nv_busy, nv_recall_done, p;
    logic wel_cmd_ok, cmd_valid, serial_write_ok, array_addr_protected;
    logic [7:0] nv_status_in, nv_status_out, cmd_opcode, status_byte, rx, exp;
    logic [15:0] array_addr;
    logic [15:0] adr_tab [6] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000, 16'hFFFF};
    int bad_count = 0;
    int check_count = 0;
    always #5 sys_clk = ~sys_clk;
    nvss_status_protect u_dut (.*);
    nvss_spi_host u_host (.*);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic results;
        if (bad_count == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n);
        u_host.frame({op, d, 8'h00}, n, rx);
    endtask
    task automatic wr(input logic [7:0] d);
        cmd(8'h06, 8'h00, 8);
        cmd(8'h01, d, 16);
    endtask
    // Fast read carries a dummy byte, so it takes three bytes
    task automatic rd(input logic [7:0] op, input logic [7:0] want);
        cmd(op, 8'h00, (op == 8'h09) ? 24 : 16);
        check("status read", rx, want);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        wp_n = 1'b1;
        nv_busy = 1'b0;
        nv_recall_done = 1'b0;
        nv_status_in = 8'h00;
        array_addr = 16'h0000;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        repeat (4) @(negedge sys_clk);
        check("status view", status_byte, 8'h00);
        rd(8'h05, 8'h00);
        cmd(8'h01, 8'h06, 16);
        rd(8'h05, 8'h00);
        cmd(8'h06, 8'h00, 8);
        rd(8'h05, 8'h02);
        cmd(8'h01, 8'h33, 16);
        rd(8'h05, 8'h00);
        for (int k = 0; k < 4; k++) begin
            wr({4'h3, k[1:0], 2'b11});
            exp = {4'h0, k[1:0], 2'b00};
            rd(8'h09, exp);
            check("volatile copy", nv_status_out, exp);
            foreach (adr_tab[i]) begin
                array_addr = adr_tab[i];
                repeat (4) @(negedge sys_clk);
                p = k == 3 || (k == 2 && array_addr[15]) || (k == 1 && &array_addr[15:14]);
                check("protect", {7'h00, array_addr_protected}, {7'h00, p});
            end
        end
        cmd(8'h06, 8'h00, 8);
        cmd(8'h04, 8'h00, 8);
        rd(8'h05, 8'h0C);
        cmd(8'h06, 8'h00, 8);
        cmd(8'h01, 8'h00, 12);
        rd(8'h05, 8'h0C);
        wp_n = 1'b0;
        wr(8'h80);
        rd(8'h05, 8'h80);
        wr(8'h0C);
        rd(8'h05, 8'h80);
        wp_n = 1'b1;
        cmd(8'h06, 8'h00, 8);
        check("serial gate", {7'h00, serial_write_ok}, 8'h01);
        cmd(8'h01, 8'h40, 16);
        wr(8'h00);
        rd(8'h05, 8'h40);
        cmd(8'h06, 8'h00, 8);
        check("serial gate", {7'h00, serial_write_ok}, 8'h00);
        nv_busy = 1'b1;
        wr(8'h01);
        rd(8'h05, 8'h41);
        nv_busy = 1'b0;
        rd(8'h05, 8'h40);
        results();
    end
    // Whole run needs about 10k cycles
    initial begin
        repeat (40000) @(posedge sys_clk);
        bad_count++;
        results();
    end
endmodule // nvss_status_protect_tb_top

// ---- verilog/nvss_defines.vh ----
// Constants of the status and write-protection block of the serial nvSRAM
// Behaviour
// - Eight-bit status: 7 pin enable, 6 serial lock, 3/2 block protect, 1 latch, 0 busy.
// - Busy bit follows store or recall activity; no instruction changes it.
// - Status write changes only bits 2, 3, 6 and 7.
// - Bits 5 and 4 always read zero and store nothing.
// - Shipped state holds zero in all bits but busy.
// - Serial number writes allowed while serial lock is zero, refused once set.
// - Serial lock is write-once; a status write never clears it.
// - Read status opcode up to 40 MHz shifts out current status byte.
// - Fast read status sends one dummy byte before the status byte.
// - Status write takes one data byte, loaded only if latch was set.
// - Written status is volatile until a store copies it to nonvolatile cells.
// - Write-class instructions need the latch set; otherwise refused.
// - Refused write instruction is ignored until chip select rises again.
// - Set-latch opcode sets the latch; power-up clears it.
// - Latch clears when any write-class or nonvolatile special instruction completes.
// - Clear-latch opcode clears the latch at the closing chip select rise.
// - Block protect 00 none, 01 C000-FFFF, 10 8000-FFFF, 11 all.
// - Write-protect pin matters only while pin enable is one.
// - Pin low with pin enable one refuses every status write.
// - Opcodes 05 read status, 09 fast read status, 01 write status.
// - Opcodes 06 set latch, 04 clear latch.
// - MSB first; every instruction starts at chip select falling edge.
`ifndef NVSS_DEFINES_VH
`define NVSS_DEFINES_VH

`define NVSS_BIT_BUSY 0
`define NVSS_BIT_WEL 1
`define NVSS_BIT_BP_LO 2
`define NVSS_BIT_BP_HI 3
`define NVSS_BIT_SLOCK 6
`define NVSS_BIT_PPEN 7
`define NVSS_WR_MASK 8'hCC
`define NVSS_NV_RESET 8'h00

`define NVSS_OP_RD_STATUS 8'h05
`define NVSS_OP_FAST_RD_STATUS 8'h09
`define NVSS_OP_WR_STATUS 8'h01
`define NVSS_OP_SET_WEL 8'h06
`define NVSS_OP_CLR_WEL 8'h04
`define NVSS_OP_WRITE 8'h02
`define NVSS_OP_STORE 8'h3C
`define NVSS_OP_RECALL 8'h60
`define NVSS_OP_AS_ON 8'h59
`define NVSS_OP_AS_OFF 8'h19
`define NVSS_OP_WR_SERIAL 8'hC2

`define NVSS_PROT_QTR_BASE 16'hC000
`define NVSS_PROT_HALF_BASE 16'h8000

`endif

// ---- verilog/nvss_status_protect.v ----
// Status byte, write-enable latch and block-protect decode of an SPI nvSRAM
`include "nvss_defines.vh"

module nvss_status_protect (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // SPI pins
    input wire spi_sck,
    input wire spi_cs_n,
    input wire spi_si,
    output reg spi_so,
    output reg spi_so_oe,
    // Write-protect pin
    input wire wp_n,
    // Nonvolatile engine
    input wire nv_busy,
    input wire nv_recall_done,
    input wire [7:0] nv_status_in,
    output reg [7:0] nv_status_out,
    // Command hand-off to the rest of the device
    output reg wel_cmd_ok,
    output reg [7:0] cmd_opcode,
    output reg cmd_valid,
    output reg serial_write_ok,
    // Array write gate
    input wire [15:0] array_addr,
    output reg array_addr_protected,
    // Status view
    output reg [7:0] status_byte
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    wire sck_s;
    wire cs_n_s;
    wire si_s;
    wire wp_n_s;

    nvss_sync #(.RST_VAL(1'b0)) u_sck (.sys_clk(sys_clk), .rst(rst), .d_in(spi_sck),
        .q_out(sck_s));
    nvss_sync #(.RST_VAL(1'b1)) u_cs (.sys_clk(sys_clk), .rst(rst), .d_in(spi_cs_n),
        .q_out(cs_n_s));
    nvss_sync #(.RST_VAL(1'b0)) u_si (.sys_clk(sys_clk), .rst(rst), .d_in(spi_si),
        .q_out(si_s));
    nvss_sync #(.RST_VAL(1'b1)) u_wp (.sys_clk(sys_clk), .rst(rst), .d_in(wp_n),
        .q_out(wp_n_s));

    reg sck_d_r;
    reg cs_n_d_r;
    wire sck_rise = sck_s & ~sck_d_r;
    wire sck_fall = ~sck_s & sck_d_r;
    wire cs_fall = ~cs_n_s & cs_n_d_r;
    wire cs_rise = cs_n_s & ~cs_n_d_r;
    wire sel = ~cs_n_s;

    ////////////////////////////////////////////////////////////////////////
    // Frame state
    localparam ST_IDLE = 5'b00001;
    localparam ST_OPC = 5'b00010;
    localparam ST_DUMMY = 5'b00100;
    localparam ST_DATA = 5'b01000;
    localparam ST_IGNORE = 5'b10000;

    reg [4:0] state_r;
    reg [4:0] state_nxt;
    reg [2:0] bit_cnt_r;
    reg [7:0] shift_r;
    reg [7:0] opcode_r;
    reg [7:0] out_r;
    reg out_phase_r;
    reg wel_r;
    reg [7:0] nv_bits_r;
    reg wr_commit_r;
    reg wel_clear_r;
    reg [7:0] wr_data_r;
    reg wp_lock_r;

    wire [7:0] byte_in = {shift_r[6:0], si_s};
    wire byte_done = sck_rise & (bit_cnt_r == 3'd7);
    // Unused bits 5:4 are never stored, so they always read as zero
    wire [7:0] stat_now = {nv_bits_r[7:6], 2'b00, nv_bits_r[3:2], wel_r, nv_busy};

    wire is_wr_class = (byte_in == `NVSS_OP_WR_STATUS) | (byte_in == `NVSS_OP_WRITE) |
        (byte_in == `NVSS_OP_WR_SERIAL) | (byte_in == `NVSS_OP_STORE) |
        (byte_in == `NVSS_OP_RECALL) | (byte_in == `NVSS_OP_AS_ON) |
        (byte_in == `NVSS_OP_AS_OFF);
    wire is_rd_status = (byte_in == `NVSS_OP_RD_STATUS) |
        (byte_in == `NVSS_OP_FAST_RD_STATUS);

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cs_fall) begin
                    state_nxt = ST_OPC;
                end
            end
            ST_OPC: begin
                if (byte_done) begin
                    if (is_wr_class & ~wel_r) begin
                        state_nxt = ST_IGNORE;
                    end else if (byte_in == `NVSS_OP_FAST_RD_STATUS) begin
                        state_nxt = ST_DUMMY;
                    end else if (is_rd_status | (byte_in == `NVSS_OP_WR_STATUS)) begin
                        state_nxt = ST_DATA;
                    end else begin
                        state_nxt = ST_IGNORE;
                    end
                end
            end
            ST_DUMMY: begin
                if (byte_done) begin
                    state_nxt = ST_DATA;
                end
            end
            ST_DATA: begin
                // Status reads repeat the byte; a write ignores bytes after the first
                state_nxt = ST_DATA;
            end
            ST_IGNORE: begin
                state_nxt = ST_IGNORE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (cs_rise | ~sel) begin
            state_nxt = ST_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shifting and status update
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sck_d_r <= 1'b0;
            cs_n_d_r <= 1'b1;
            state_r <= ST_IDLE;
            bit_cnt_r <= 3'd0;
            shift_r <= 8'h00;
            opcode_r <= 8'h00;
            out_r <= 8'h00;
            out_phase_r <= 1'b0;
            wel_r <= 1'b0;
            nv_bits_r <= `NVSS_NV_RESET;
            wr_commit_r <= 1'b0;
            wel_clear_r <= 1'b0;
            wr_data_r <= 8'h00;
            wp_lock_r <= 1'b0;
            spi_so <= 1'b0;
            spi_so_oe <= 1'b0;
            cmd_opcode <= 8'h00;
            cmd_valid <= 1'b0;
        end else begin
            sck_d_r <= sck_s;
            cs_n_d_r <= cs_n_s;
            state_r <= state_nxt;
            cmd_valid <= 1'b0;
            if (cs_fall) begin
                bit_cnt_r <= 3'd0;
                wr_commit_r <= 1'b0;
                wel_clear_r <= 1'b0;
                out_phase_r <= 1'b0;
                // Pin sampled at frame start; a later fall leaves the frame alone
                wp_lock_r <= nv_bits_r[`NVSS_BIT_PPEN] & ~wp_n_s;
            end else if (sel & sck_rise) begin
                shift_r <= byte_in;
                bit_cnt_r <= bit_cnt_r + 3'd1;
            end
            if (state_r == ST_OPC && byte_done) begin
                opcode_r <= byte_in;
                out_r <= stat_now;
                if (!(is_wr_class & ~wel_r)) begin
                    cmd_opcode <= byte_in;
                    cmd_valid <= 1'b1;
                end
                if (byte_in == `NVSS_OP_SET_WEL) begin
                    wel_r <= 1'b1;
                end
                if ((byte_in == `NVSS_OP_CLR_WEL) | (is_wr_class & wel_r)) begin
                    wel_clear_r <= 1'b1;
                end
            end
            if (state_r == ST_DUMMY && byte_done) begin
                out_r <= stat_now;
            end
            if (state_r == ST_DATA && opcode_r == `NVSS_OP_WR_STATUS && byte_done &&
                !wr_commit_r) begin
                wr_data_r <= byte_in;
                wr_commit_r <= 1'b1;
            end
            // Output shifts on sck falls; the byte reloads after each eight bits
            if (state_r == ST_DATA && opcode_r != `NVSS_OP_WR_STATUS) begin
                if (sck_fall) begin
                    spi_so_oe <= 1'b1;
                    spi_so <= out_r[7];
                    out_r <= {out_r[6:0], 1'b0};
                    out_phase_r <= 1'b1;
                end
                if (byte_done & out_phase_r) begin
                    out_r <= stat_now;
                end
            end
            if (cs_rise) begin
                spi_so_oe <= 1'b0;
                if (wel_clear_r) begin
                    wel_r <= 1'b0;
                end
                if (wr_commit_r && !wp_lock_r) begin
                    // Lock bit is sticky: OR keeps a one once it is there
                    nv_bits_r <= (nv_bits_r & ~`NVSS_WR_MASK) |
                        (wr_data_r & `NVSS_WR_MASK) |
                        (nv_bits_r & (8'h01 << `NVSS_BIT_SLOCK));
                end
            end else if (nv_recall_done) begin
                // Recall reloads the saved copy; written values stay volatile till store
                nv_bits_r <= nv_status_in & `NVSS_WR_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs
    reg [15:0] prot_base;
    reg prot_any;

    always @* begin
        prot_any = 1'b1;
        prot_base = 16'h0000;
        case ({nv_bits_r[`NVSS_BIT_BP_HI], nv_bits_r[`NVSS_BIT_BP_LO]})
            2'b00: begin
                prot_any = 1'b0;
            end
            2'b01: begin
                prot_base = `NVSS_PROT_QTR_BASE;
            end
            2'b10: begin
                prot_base = `NVSS_PROT_HALF_BASE;
            end
            default: begin
                prot_base = 16'h0000;
            end
        endcase
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status_byte <= 8'h00;
            nv_status_out <= 8'h00;
            wel_cmd_ok <= 1'b0;
            serial_write_ok <= 1'b0;
            array_addr_protected <= 1'b0;
        end else begin
            status_byte <= stat_now;
            nv_status_out <= nv_bits_r & `NVSS_WR_MASK;
            wel_cmd_ok <= wel_r;
            serial_write_ok <= wel_r & ~nv_bits_r[`NVSS_BIT_SLOCK];
            array_addr_protected <= prot_any & (array_addr >= prot_base);
        end
    end
endmodule // nvss_status_protect

// ---- verilog/nvss_sync.v ----
// Two-flop synchroniser for pins entering the sys_clk domain
module nvss_sync (
    // Clock and reset
    input wire sys_clk,
    input wire rst,
    // Data
    input wire d_in,
    output reg q_out
);
    parameter RST_VAL = 1'b0;
    reg meta_r;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule // nvss_sync
